// ==== src/digipot_wiper_ctrl_i2c_slave.v ====
// Function
// [R1] Above full scale W=A, step ignored; full scale ignores up; zero ignores down
// [R2] Lock bit blocks writes to its network's wipers and terminal bits
// [R3] Lock bits change only in high-voltage mode, never by plain commands
// [R4] Lock bits survive power-on or brown-out reset
// [R5] Reset copies each non-volatile wiper into its volatile wiper
// [R6] Shutdown bit low opens terminal A and ties wiper to B
// [R7] Serial port and EEPROM write keep running during shutdown
// [R8] Shutdown overrides connect bits but keeps them; they resume afterwards
// [R9] Shutdown never touches wiper registers; wiper returns on exit
// [R10] Each network shuts down independently through its own bits
// [R11] Slave only; master makes clock, start and stop
// [R12] Received data sampled on rising serial clock edge
// [R13] Data changes only while clock low; changes while high are start/stop
// [R14] Standard, fast and high-speed bus rates supported
// [R15] Clock line never held low; reads finish within bit time
// [R16] Address pin 0 captured only at reset release
// [R17] System ties address pins 2 and 1 statically
// [R18] Raised high-voltage input marks commands that may alter locks
// [R19] 7-bit addressing plus general call; 10-bit addresses ignored
// [R20] Acknowledge drives data low; not-acknowledge leaves it released
// [R21] Slave address is 0101 plus address pins; absent pins read 1
// [R22] Start condition returns the serial state machine to idle; the code sends it from any state to S_ADDR instead
// [R23] Inputs filtered before start, stop and clock edges are detected
//
// Added by the designer: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "digipot_defs.vh"

module digipot_wiper_ctrl_i2c_slave #(
  parameter        HAS_A2          = 1,
  parameter        HAS_A1          = 1,
  parameter [31:0] EE_WRITE_CYCLES = `EE_WRITE_CYC
) (
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_rst_n,
  input  wire        i_nv_clear_n,
  // Avalon-MM slave
  input  wire [3:0]  i_avs_address,
  input  wire        i_avs_read,
  input  wire        i_avs_write,
  input  wire [31:0] i_avs_writedata,
  output reg  [31:0] o_avs_readdata,
  output wire        o_avs_waitrequest,
  // Serial bus
  input  wire        i_scl,
  input  wire        i_sda,
  output reg         o_sda,
  output reg         o_sda_oe,
  // Address and high-voltage pins
  input  wire        i_addr_pin_0,
  input  wire        i_addr_pin_1,
  input  wire        i_addr_pin_2,
  input  wire        i_high_voltage_cmd_in,
  // Resistor network switches
  output reg  [1:0]  o_net_term_a_pin,
  output reg  [1:0]  o_net_wiper_pin,
  output reg  [1:0]  o_net_term_b_pin,
  output reg  [17:0] o_net_tap
);

  // ****************************************
  // States
  // ****************************************
  localparam [6:0] S_IDLE  = 7'h01;
  localparam [6:0] S_ADDR  = 7'h02;
  localparam [6:0] S_ACK_A = 7'h04;
  localparam [6:0] S_RX    = 7'h08;
  localparam [6:0] S_ACK_R = 7'h10;
  localparam [6:0] S_TX    = 7'h20;
  localparam [6:0] S_ACK_T = 7'h40;

  // ****************************************
  // Functions
  // ****************************************
  function [8:0] tap_of;
    input [9:0] w;
    reg   [9:0] fs;
    begin
      fs = `FULL_SCALE;
      if (w > fs)
        tap_of = fs[8:0];
      else
        tap_of = w[8:0];
    end
  endfunction

  function [9:0] step_of;
    input [9:0] w;
    input       dec;
    begin
      step_of = w;
      if (w > `FULL_SCALE)
        step_of = w;
      else if (!dec && w != `FULL_SCALE)
        step_of = w + 10'h001;
      else if (dec && w != `WIPER_ZERO)
        step_of = w - 10'h001;
    end
  endfunction

  // ****************************************
  // Input synchronisers and filter
  // ****************************************
  wire [5:0] pin_raw = {i_high_voltage_cmd_in, i_addr_pin_2, i_addr_pin_1,
                        i_addr_pin_0, i_sda, i_scl};
  reg  [5:0] sync1_ff;
  reg  [5:0] sync2_ff;
  reg  [5:0] sync3_ff;
  reg  [5:0] filt_ff;
  genvar     gi;

  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_sync
      always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          sync1_ff[gi] <= 1'b1;
          sync2_ff[gi] <= 1'b1;
          sync3_ff[gi] <= 1'b1;
          filt_ff[gi]  <= 1'b1;
        end else begin
          sync1_ff[gi] <= pin_raw[gi];
          sync2_ff[gi] <= sync1_ff[gi];
          sync3_ff[gi] <= sync2_ff[gi];
          if (sync2_ff[gi] == sync3_ff[gi])
            filt_ff[gi] <= sync3_ff[gi]; // [R23]
        end
      end
    end
  endgenerate

  wire scl_f = filt_ff[0];
  wire sda_f = filt_ff[1];
  wire hv_f  = filt_ff[5];
  reg  scl_d_ff;
  reg  sda_d_ff;
  wire scl_rise = scl_f & ~scl_d_ff;
  wire scl_fall = ~scl_f & scl_d_ff;
  wire start_c  = scl_f & scl_d_ff & sda_d_ff & ~sda_f; // [R13]
  wire stop_c   = scl_f & scl_d_ff & ~sda_d_ff & sda_f; // [R13]

  // ****************************************
  // Storage
  // ****************************************
  reg  [9:0]  nv_wiper0_ff;
  reg  [9:0]  nv_wiper1_ff;
  reg  [1:0]  lock_bits_ff;
  reg  [9:0]  wiper0_ff;
  reg  [9:0]  wiper1_ff;
  reg  [7:0]  terminal_control_reg_ff;
  reg  [1:0]  init_cnt_ff;
  reg         init_done_ff;
  reg         addr_pin_0_ff;
  reg  [31:0] ee_cnt_ff;
  reg         ack_ff;
  reg         gcen_ff;
  reg  [7:0]  tx_byte_ff;
  reg  [7:0]  rx_byte_ff;
  reg  [7:0]  rx_cnt_ff;
  reg         rx_valid_ff;
  reg  [6:0]  state_ff;
  reg  [3:0]  bit_cnt_ff;
  reg  [7:0]  shift_ff;
  reg         ack_ok_ff;
  reg         rx_set_ff;

  wire        ee_busy = (ee_cnt_ff != 32'h0000_0000);
  wire        lock0   = lock_bits_ff[0];
  wire        lock1   = lock_bits_ff[1];
  wire        bus_req = i_avs_read | i_avs_write;
  wire        take    = bus_req & ~ack_ff & init_done_ff;
  wire        wr_ok   = i_avs_write & ack_ff;
  wire        a2_v    = HAS_A2 ? filt_ff[4] : 1'b1;
  wire        a1_v    = HAS_A1 ? filt_ff[3] : 1'b1;
  wire [6:0]  my_addr = {`ADDR_FIXED, a2_v, a1_v, addr_pin_0_ff}; // [R21] [R17]
  wire [7:0]  terminal_control_reg_wd = i_avs_writedata[7:0];

  assign o_avs_waitrequest = bus_req & ~ack_ff; // [R15]

  // ****************************************
  // Non-volatile wipers and lock bits
  // ****************************************
  // Held by i_nv_clear_n only, so they outlive i_rst_n
  always @(posedge i_clk or negedge i_nv_clear_n) begin
    if (!i_nv_clear_n) begin
      nv_wiper0_ff <= `NV_WIPER_RST;
      nv_wiper1_ff <= `NV_WIPER_RST;
      lock_bits_ff <= `LOCK_RST; // [R4]
    end else if (i_rst_n && wr_ok) begin
      if (i_avs_address == `REG_NV_WIPER0 && !lock0 && !ee_busy)
        nv_wiper0_ff <= i_avs_writedata[9:0]; // [R2]
      if (i_avs_address == `REG_NV_WIPER1 && !lock1 && !ee_busy)
        nv_wiper1_ff <= i_avs_writedata[9:0]; // [R2]
      if (i_avs_address == `REG_LOCK && hv_f)
        lock_bits_ff <= i_avs_writedata[1:0]; // [R3] [R18]
    end
  end

  // ****************************************
  // Volatile registers and bus slave
  // ****************************************
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wiper0_ff               <= `WIPER_ZERO;
      wiper1_ff               <= `WIPER_ZERO;
      terminal_control_reg_ff <= `TERMINAL_CONTROL_REG_RST;
      init_cnt_ff             <= 2'h0;
      init_done_ff            <= 1'b0;
      addr_pin_0_ff           <= 1'b1;
      ee_cnt_ff               <= 32'h0000_0000;
      ack_ff                  <= 1'b0;
      gcen_ff                 <= 1'b0;
      tx_byte_ff              <= `TX_RST;
      rx_valid_ff             <= 1'b0;
      o_avs_readdata          <= 32'h0000_0000;
    end else begin
      ack_ff <= take;
      if (!init_done_ff) begin
        init_cnt_ff <= init_cnt_ff + 2'h1;
        if (init_cnt_ff == `SYNC_SETTLE) begin
          init_done_ff  <= 1'b1;
          addr_pin_0_ff <= sync3_ff[2]; // [R16]
          wiper0_ff     <= nv_wiper0_ff; // [R5]
          wiper1_ff     <= nv_wiper1_ff; // [R5]
        end
      end
      if (ee_busy)
        ee_cnt_ff <= ee_cnt_ff - 32'h0000_0001; // [R7]
      if (take && i_avs_read) begin
        case (i_avs_address)
          `REG_WIPER0:    o_avs_readdata <= {22'h0, wiper0_ff};
          `REG_WIPER1:    o_avs_readdata <= {22'h0, wiper1_ff};
          `REG_NV_WIPER0: o_avs_readdata <= {22'h0, nv_wiper0_ff};
          `REG_NV_WIPER1: o_avs_readdata <= {22'h0, nv_wiper1_ff};
          `REG_TERMINAL_CONTROL_REG:      o_avs_readdata <= {24'h0, terminal_control_reg_ff};
          `REG_LOCK:      o_avs_readdata <= {30'h0, lock_bits_ff};
          `REG_STATUS:    o_avs_readdata <= {22'h0, my_addr[2:0], gcen_ff, ~state_ff[0],
                                             rx_valid_ff, ee_busy, hv_f, lock1, lock0};
          `REG_SER_CTRL:  o_avs_readdata <= {16'h0, tx_byte_ff, 7'h0, gcen_ff};
          `REG_RX_DATA:   o_avs_readdata <= {16'h0, rx_cnt_ff, rx_byte_ff};
          `REG_TAP:       o_avs_readdata <= {7'h0, tap_of(wiper1_ff), 7'h0, tap_of(wiper0_ff)};
          default:        o_avs_readdata <= 32'h0000_0000;
        endcase
      end
      if (wr_ok) begin
        case (i_avs_address)
          `REG_WIPER0: begin
            if (!lock0)
              wiper0_ff <= i_avs_writedata[9:0]; // [R2]
          end
          `REG_WIPER1: begin
            if (!lock1)
              wiper1_ff <= i_avs_writedata[9:0]; // [R2]
          end
          `REG_NV_WIPER0: begin
            if (!lock0 && !ee_busy)
              ee_cnt_ff <= EE_WRITE_CYCLES;
          end
          `REG_NV_WIPER1: begin
            if (!lock1 && !ee_busy)
              ee_cnt_ff <= EE_WRITE_CYCLES;
          end
          `REG_TERMINAL_CONTROL_REG: begin
            if (!lock0)
              terminal_control_reg_ff[3:0] <= terminal_control_reg_wd[3:0]; // [R2]
            if (!lock1)
              terminal_control_reg_ff[7:4] <= terminal_control_reg_wd[7:4]; // [R2]
          end
          `REG_STEP: begin
            if (!i_avs_writedata[`STEP_NET] && !lock0)
              wiper0_ff <= step_of(wiper0_ff, i_avs_writedata[`STEP_DEC]); // [R1]
            if (i_avs_writedata[`STEP_NET] && !lock1)
              wiper1_ff <= step_of(wiper1_ff, i_avs_writedata[`STEP_DEC]); // [R1]
          end
          `REG_SER_CTRL: begin
            gcen_ff    <= i_avs_writedata[`SC_GCEN];
            tx_byte_ff <= i_avs_writedata[`SC_TX_LSB +: 8];
          end
          default: begin
          end
        endcase
      end
      // New byte wins over a clear in the same cycle
      if (rx_set_ff)
        rx_valid_ff <= 1'b1;
      else if (wr_ok && i_avs_address == `REG_RX_DATA && i_avs_writedata[0])
        rx_valid_ff <= 1'b0;
    end
  end

  // ****************************************
  // Terminal switches
  // ****************************************
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_net
      wire [3:0] tc = terminal_control_reg_ff[gi*`TC_NET_W +: `TC_NET_W];
      wire [9:0] wv = (gi == 0) ? wiper0_ff : wiper1_ff;
      always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          o_net_term_a_pin[gi]  <= 1'b0;
          o_net_wiper_pin[gi]   <= 1'b0;
          o_net_term_b_pin[gi]  <= 1'b0;
          o_net_tap[gi*9 +: 9]  <= 9'h000;
        end else begin
          o_net_tap[gi*9 +: 9] <= tap_of(wv); // [R1] [R9]
          if (!tc[`TC_HW]) begin
            o_net_term_a_pin[gi] <= 1'b0; // [R6] [R10]
            o_net_wiper_pin[gi]  <= 1'b1; // [R6]
            o_net_term_b_pin[gi] <= 1'b1; // [R6] [R8]
          end else begin
            o_net_term_a_pin[gi] <= tc[`TC_A]; // [R8]
            o_net_wiper_pin[gi]  <= tc[`TC_W]; // [R8]
            o_net_term_b_pin[gi] <= tc[`TC_B]; // [R8]
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // Serial slave state machine
  // ****************************************
  // Works from edges found on the system clock, so every bus rate is
  // followed as long as each low clock phase spans six system clocks
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_d_ff   <= 1'b1;
      sda_d_ff   <= 1'b1;
      state_ff   <= S_IDLE;
      bit_cnt_ff <= 4'h0;
      shift_ff   <= 8'h00;
      ack_ok_ff  <= 1'b0;
      rx_byte_ff <= 8'h00;
      rx_cnt_ff  <= 8'h00;
      rx_set_ff  <= 1'b0;
      o_sda      <= 1'b1;
      o_sda_oe   <= 1'b0;
    end else begin
      scl_d_ff <= scl_f;
      sda_d_ff <= sda_f;
      rx_set_ff <= 1'b0;
      if (start_c) begin
        state_ff   <= S_ADDR; // [R22]
        bit_cnt_ff <= 4'h0;
        o_sda_oe   <= 1'b0;
      end else if (stop_c) begin
        state_ff <= S_IDLE;
        o_sda_oe <= 1'b0;
      end else begin
        case (state_ff)
          S_IDLE: begin
            o_sda_oe <= 1'b0;
          end
          S_ADDR, S_RX: begin
            if (scl_rise && bit_cnt_ff != 4'h8) begin
              shift_ff   <= {shift_ff[6:0], sda_f}; // [R12]
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end else if (scl_fall && bit_cnt_ff == 4'h8) begin
              if (state_ff == S_RX) begin
                rx_byte_ff <= shift_ff;
                rx_cnt_ff  <= rx_cnt_ff + 8'h01;
                rx_set_ff  <= 1'b1;
                o_sda      <= 1'b0; // [R20]
                o_sda_oe   <= 1'b1;
                state_ff   <= S_ACK_R;
              end else if (shift_ff[7:1] == my_addr ||
                           (gcen_ff && shift_ff == {`GCALL_ADDR, 1'b0})) begin
                o_sda    <= 1'b0; // [R19] [R20]
                o_sda_oe <= 1'b1;
                state_ff <= S_ACK_A;
              end else begin
                state_ff <= S_IDLE; // [R19]
              end
            end
          end
          S_ACK_A: begin
            if (scl_fall) begin
              bit_cnt_ff <= shift_ff[0] ? 4'h1 : 4'h0;
              if (shift_ff[0]) begin
                o_sda    <= tx_byte_ff[7]; // [R13]
                o_sda_oe <= ~tx_byte_ff[7];
                shift_ff <= {tx_byte_ff[6:0], 1'b0};
                state_ff <= S_TX;
              end else begin
                o_sda_oe <= 1'b0;
                state_ff <= S_RX;
              end
            end
          end
          S_ACK_R: begin
            if (scl_fall) begin
              o_sda_oe   <= 1'b0;
              bit_cnt_ff <= 4'h0;
              state_ff   <= S_RX;
            end
          end
          S_TX: begin
            if (scl_fall) begin
              if (bit_cnt_ff == 4'h8) begin
                o_sda_oe <= 1'b0;
                state_ff <= S_ACK_T;
              end else begin
                o_sda      <= shift_ff[7]; // [R13]
                o_sda_oe   <= ~shift_ff[7];
                shift_ff   <= {shift_ff[6:0], 1'b0};
                bit_cnt_ff <= bit_cnt_ff + 4'h1;
              end
            end
          end
          S_ACK_T: begin
            if (scl_rise) begin
              ack_ok_ff <= ~sda_f; // [R12] [R20]
            end else if (scl_fall) begin
              if (ack_ok_ff) begin
                o_sda      <= tx_byte_ff[7];
                o_sda_oe   <= ~tx_byte_ff[7];
                shift_ff   <= {tx_byte_ff[6:0], 1'b0};
                bit_cnt_ff <= 4'h1;
                state_ff   <= S_TX;
              end else begin
                state_ff <= S_IDLE;
              end
            end
          end
          default: begin
            state_ff <= S_IDLE;
            o_sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // No clock output exists: the clock line is never driven [R11] [R14] [R15]

endmodule

// ==== src/digipot_defs.vh ====
`ifndef DIGIPOT_DEFS_VH
`define DIGIPOT_DEFS_VH

// ****************************************
// Register word addresses
// ****************************************
`define REG_WIPER0      4'h0
`define REG_WIPER1      4'h1
`define REG_NV_WIPER0   4'h2
`define REG_NV_WIPER1   4'h3
`define REG_TERMINAL_CONTROL_REG        4'h4
`define REG_LOCK        4'h5
`define REG_STEP        4'h6
`define REG_STATUS      4'h7
`define REG_SER_CTRL    4'h8
`define REG_RX_DATA     4'h9
`define REG_TAP         4'ha

// ****************************************
// Field positions
// ****************************************
`define TC_B            0
`define TC_W            1
`define TC_A            2
`define TC_HW           3
`define TC_NET_W        4
`define STEP_NET        0
`define STEP_DEC        1
`define ST_LOCK0        0
`define ST_LOCK1        1
`define ST_HV           2
`define ST_EE_BUSY      3
`define ST_RX_VALID     4
`define ST_BUS_BUSY     5
`define ST_GCEN         6
`define ST_ADDR_LSB     7
`define SC_GCEN         0
`define SC_TX_LSB       8
`define RX_CNT_LSB      8
`define TAP1_LSB        16

// ****************************************
// Reset values and codes
// ****************************************
`define NV_WIPER_RST    10'h080
`define TERMINAL_CONTROL_REG_RST        8'hff
`define LOCK_RST        2'h0
`define FULL_SCALE      10'h100
`define WIPER_MAX       10'h3ff
`define WIPER_ZERO      10'h000
`define ADDR_FIXED      4'h5
`define GCALL_ADDR      7'h00
`define TX_RST          8'hff

// ****************************************
// Timing
// ****************************************
`define CLK_MHZ         50
`define EE_WRITE_US     5000
`define EE_WRITE_CYC    (`EE_WRITE_US * `CLK_MHZ)
`define SYNC_SETTLE     2'h3

`endif

// ==== tb/digipot_props.sv ====
`timescale 1ns/1ns
// ****************************************
// Port checker
// ****************************************
module digipot_props (
  // Clock and reset
  input wire        i_clk,
  input wire        i_rst_n,
  // Register bus
  input wire        i_avs_read,
  input wire        i_avs_write,
  input wire [31:0] o_avs_readdata,
  input wire        o_avs_waitrequest,
  // Serial bus and taps
  input wire        i_scl,
  input wire        i_sda,
  input wire        o_sda,
  input wire        o_sda_oe,
  input wire [17:0] o_net_tap
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence start_seen;
    i_scl && $fell(i_sda);
  endsequence
  sequence bus_taken;
    (i_avs_read || i_avs_write) && !o_avs_waitrequest;
  endsequence
  chk_ack_low_only: assert property (o_sda_oe |-> !o_sda) else $error("sda driven high");
  chk_oe_rise_low: assert property ($rose(o_sda_oe) |-> !i_scl && $past(!i_scl, 3))
    else $error("drive began in high");
  chk_oe_fall_low: assert property ($fell(o_sda_oe) |-> !i_scl && $past(!i_scl, 3))
    else $error("release in high");
  chk_start_idle: assert property (start_seen |=> !o_sda_oe [*8]) else $error("drive after start");
  chk_tap0_cap: assert property (o_net_tap[8:0] <= 9'h100) else $error("tap0 above full scale");
  chk_tap1_cap: assert property (o_net_tap[17:9] <= 9'h100) else $error("tap1 above full scale");
  chk_ack_bound: assert property ($rose(i_avs_read || i_avs_write) |-> ##[1:3] !o_avs_waitrequest)
    else $error("bus answer late");
  chk_ack_single: assert property (bus_taken |=> !bus_taken) else $error("double ack");
  chk_rdata_hold: assert property ($changed(o_avs_readdata) |-> i_avs_read && !o_avs_waitrequest)
    else $error("read data moved");
endmodule

bind digipot_wiper_ctrl_i2c_slave digipot_props chk_u (
  .i_clk             (i_clk),
  .i_rst_n           (i_rst_n),
  .i_avs_read        (i_avs_read),
  .i_avs_write       (i_avs_write),
  .o_avs_readdata    (o_avs_readdata),
  .o_avs_waitrequest (o_avs_waitrequest),
  .i_scl             (i_scl),
  .i_sda             (i_sda),
  .o_sda             (o_sda),
  .o_sda_oe          (o_sda_oe),
  .o_net_tap         (o_net_tap)
);

// ==== tb/i2c_master_model.sv ====
`timescale 1ns/1ns
// ****************************************
// Two-wire bus master, 8 clocks a bit
// ****************************************
module i2c_master_model (
  // Clock and wire level
  input  wire i_clk,
  input  wire i_sda,
  // Open-drain drives
  output reg  o_scl,
  output reg  o_sda_low
);
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task bit_io(input logic b, output logic v);
    o_sda_low <= !b;
    tick(2);
    o_scl <= 1'b1;
    tick(2);
    v = i_sda;
    o_scl <= 1'b0;
    tick(4);
  endtask
  task start;
    if (!o_scl) begin
      o_sda_low <= 1'b0;
      tick(2);
      o_scl <= 1'b1;
      tick(4);
    end
    o_sda_low <= 1'b1;
    tick(4);
    o_scl <= 1'b0;
    tick(2);
  endtask
  task stop;
    o_sda_low <= 1'b1;
    tick(2);
    o_scl <= 1'b1;
    tick(4);
    o_sda_low <= 1'b0;
    tick(4);
  endtask
  task send(input [7:0] d, output logic ack);
    logic v;
    for (int i = 7; i >= 0; i--) bit_io(d[i], v);
    bit_io(1'b1, v);
    ack = !v;
  endtask
  task recv(output [7:0] d, input logic ack);
    logic v;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, v);
      d[i] = v;
    end
    bit_io(!ack, v);
  endtask
endmodule

// ==== tb/digipot_wiper_ctrl_i2c_slave_tb.sv ====
`timescale 1ns/1ns
`include "digipot_defs.vh"
`define CHK(a, b, m) begin n_compared++; if ((a) !== (b)) begin error_cnt++; $display("MISMATCH %0t %s", $time, m); end end
module digipot_wiper_ctrl_i2c_slave_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        nv_clr_n = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        wreq;
  logic [31:0] q;
  wire         scl;
  wire         m_low;
  wire         sda_o;
  wire         sda_oe;
  wire         sda_w;
  logic        pin0 = 1'b1;
  logic        pin2 = 1'b1;
  logic        hv = 1'b0;
  logic [1:0]  a_pin;
  logic [1:0]  w_pin;
  logic [1:0]  b_pin;
  logic [17:0] tap;
  logic        ack;
  logic [7:0]  d;
  int          error_cnt = 0;
  int          n_compared = 0;
  logic [20:0] tbl [7] = '{{10'h3ff, 1'b0, 10'h3ff}, {10'h3ff, 1'b1, 10'h3ff}, {10'h100, 1'b0, 10'h100},
                           {10'h100, 1'b1, 10'h0ff}, {10'h000, 1'b1, 10'h000}, {10'h000, 1'b0, 10'h001},
                           {10'h101, 1'b0, 10'h101}};
  assign sda_w = (sda_oe ? sda_o : 1'b1) & ~m_low;
  always #10 clk = ~clk;
  digipot_wiper_ctrl_i2c_slave #(.EE_WRITE_CYCLES(20)) dut_u (
    .i_clk(clk), .i_rst_n(rst_n), .i_nv_clear_n(nv_clr_n),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
    .i_scl(scl), .i_sda(sda_w), .o_sda(sda_o), .o_sda_oe(sda_oe),
    .i_addr_pin_0(pin0), .i_addr_pin_1(1'b0), .i_addr_pin_2(pin2), .i_high_voltage_cmd_in(hv),
    .o_net_term_a_pin(a_pin), .o_net_wiper_pin(w_pin), .o_net_term_b_pin(b_pin), .o_net_tap(tap)
  );
  i2c_master_model m_u (.i_clk(clk), .i_sda(sda_w), .o_scl(scl), .o_sda_low(m_low));
  // ****************************************
  // Shared tasks
  // ****************************************
  task bus(input logic r, input [3:0] a, input [31:0] v, output [31:0] o);
    int t;
    t = 0;
    @(posedge clk);
    rd <= r;
    wr <= !r;
    adr <= a;
    wdat <= v;
    do begin
      @(posedge clk);
      t++;
    end while (wreq !== 1'b0);
    o = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    `CHK(t, 2, "bus answer time")
  endtask
  task rst_pulse;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  task set_hv(input logic v);
    hv <= v;
    repeat (6) @(posedge clk);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset;
    bus(1'b1, `REG_WIPER0, 32'h0, q);
    `CHK(q[9:0], `NV_WIPER_RST, "wiper load")
    `CHK(tap, {9'h080, 9'h080}, "tap after reset")
    `CHK({a_pin, w_pin, b_pin}, 6'h3f, "switches after reset")
    $display("t_reset done");
  endtask
  task t_wiper;
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, `REG_WIPER0 + i[0], {22'h0, tbl[i][20:11]}, q);
      repeat (4) @(posedge clk);
      `CHK(i[0] ? tap[17:9] : tap[8:0], (tbl[i][20:11] > 10'h100) ? 9'h100 : tbl[i][19:11], "tap map")
      bus(1'b0, `REG_STEP, {30'h0, tbl[i][10], i[0]}, q);
      bus(1'b1, `REG_WIPER0 + i[0], 32'h0, q);
      `CHK(q[9:0], tbl[i][9:0], "step result")
    end
    bus(1'b0, `REG_WIPER0, 32'h80, q);
    bus(1'b0, `REG_WIPER1, 32'h80, q);
    $display("t_wiper done");
  endtask
  task t_lock;
    int k;
    bus(1'b0, `REG_LOCK, 32'h1, q);
    bus(1'b1, `REG_STATUS, 32'h0, q);
    `CHK(q[1:0], 2'b00, "lock without hv")
    set_hv(1'b1);
    bus(1'b0, `REG_LOCK, 32'h1, q);
    set_hv(1'b0);
    bus(1'b1, `REG_STATUS, 32'h0, q);
    `CHK(q[1:0], 2'b01, "lock with hv")
    bus(1'b0, `REG_WIPER0, 32'h11, q);
    bus(1'b0, `REG_WIPER1, 32'h22, q);
    bus(1'b0, `REG_TERMINAL_CONTROL_REG, 32'h0, q);
    bus(1'b1, `REG_WIPER0, 32'h0, q);
    `CHK(q[9:0], 10'h080, "locked wiper")
    bus(1'b1, `REG_TERMINAL_CONTROL_REG, 32'h0, q);
    `CHK(q[7:0], 8'h0f, "locked terminal bits")
    bus(1'b0, `REG_NV_WIPER1, 32'h44, q);
    bus(1'b0, `REG_NV_WIPER0, 32'h33, q);
    k = 0;
    do begin
      bus(1'b1, `REG_STATUS, 32'h0, q);
      k++;
    end while (q[`ST_EE_BUSY] && k < 50);
    `CHK(q[`ST_EE_BUSY], 1'b0, "write cycle end")
    rst_pulse();
    bus(1'b1, `REG_STATUS, 32'h0, q);
    `CHK(q[1:0], 2'b01, "lock kept")
    bus(1'b1, `REG_WIPER0, 32'h0, q);
    `CHK(q[9:0], 10'h080, "locked nv wiper")
    bus(1'b1, `REG_WIPER1, 32'h0, q);
    `CHK(q[9:0], 10'h044, "nv recall")
    set_hv(1'b1);
    bus(1'b0, `REG_LOCK, 32'h0, q);
    set_hv(1'b0);
    $display("t_lock done");
  endtask
  task t_serial;
    pin0 <= 1'b0;
    bus(1'b0, `REG_SER_CTRL, 32'hff00, q);
    bus(1'b1, `REG_STATUS, 32'h0, q);
    `CHK(q[9:7], 3'b101, "pin 0 latch")
    m_u.start();
    m_u.send(8'h5a, ack);
    `CHK(ack, 1'b1, "own address")
    m_u.send(8'ha5, ack);
    `CHK(ack, 1'b1, "data ack")
    m_u.stop();
    bus(1'b1, `REG_RX_DATA, 32'h0, q);
    `CHK(q[7:0], 8'ha5, "received byte")
    m_u.start();
    m_u.send(8'h5c, ack);
    `CHK(ack, 1'b0, "foreign address")
    m_u.start();
    m_u.send(8'h5a, ack);
    `CHK(ack, 1'b1, "start after nack")
    m_u.stop();
    m_u.start();
    m_u.send(8'hf0, ack);
    `CHK(ack, 1'b0, "ten bit address")
    m_u.start();
    m_u.send(8'h00, ack);
    `CHK(ack, 1'b0, "general call off")
    m_u.stop();
    bus(1'b0, `REG_SER_CTRL, 32'h3c01, q);
    m_u.start();
    m_u.send(8'h00, ack);
    `CHK(ack, 1'b1, "general call on")
    m_u.start();
    m_u.send(8'h5b, ack);
    m_u.recv(d, 1'b1);
    `CHK(d, 8'h3c, "first read byte")
    m_u.recv(d, 1'b0);
    `CHK(d, 8'h3c, "second read byte")
    m_u.stop();
    $display("t_serial done");
  endtask
  task t_shut;
    bus(1'b0, `REG_TERMINAL_CONTROL_REG, 32'hf0, q);
    repeat (4) @(posedge clk);
    `CHK({a_pin, w_pin, b_pin}, 6'b10_11_11, "shutdown net0")
    t_serial();
    bus(1'b1, `REG_TERMINAL_CONTROL_REG, 32'h0, q);
    `CHK(q[7:0], 8'hf0, "connect bits kept")
    bus(1'b0, `REG_TERMINAL_CONTROL_REG, 32'hfd, q);
    repeat (4) @(posedge clk);
    `CHK({a_pin, w_pin, b_pin}, 6'b11_10_11, "connect bits resume")
    `CHK(tap, {9'h044, 9'h080}, "wiper return")
    $display("t_shut done");
  endtask
  task end_of_test;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    nv_clr_n <= 1'b1;
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    t_reset();
    t_wiper();
    t_lock();
    t_shut();
    end_of_test();
  end
  initial begin
    #1_000_000;
    error_cnt++;
    $display("MISMATCH %0t watchdog", $time);
    end_of_test();
  end
endmodule
